// >>> verilog/iscs_map.svh
// Address map, field positions, reset values and timing counts of the sequencer.
// Assumes it is included by bare name from the sequencer sources.
`ifndef ISCS_MAP_SVH
`define ISCS_MAP_SVH

// Upload word fields
`define ISCS_ADDR_MSB       15
`define ISCS_ADDR_LSB       12
`define ISCS_DATA_MSB       11
`define ISCS_DATA_LSB       0
`define ISCS_WORD_BITS      16

// Register addresses
`define ISCS_A_COARSE       4'h0
`define ISCS_A_FINE         4'h1
`define ISCS_A_ADC          4'h2
`define ISCS_A_GRAN         4'h3
`define ISCS_A_INT_TIME     4'h4
`define ISCS_A_PIX_ROW      4'h5
`define ISCS_A_ROWS         4'h6
`define ISCS_A_ROW_POS      4'h7

// Converter configuration bits
`define ISCS_ADC_DRIVE_BIT  0
`define ISCS_ADC_LIN_BIT    1
`define ISCS_ADC_POL_BIT    2

// Granularity fields in the granularity register
`define ISCS_COL_GRAN_LSB   0
`define ISCS_SS_GRAN_LSB    2

// Reset value of every register
`define ISCS_REG_RST        12'h000
// Fine offset midpoint for matched paths
`define ISCS_FINE_MID       7'h40

// Timing counts
`define ISCS_COL_DIV_BASE   6'h04
`define ISCS_SS_DIV_BASE    9'h020
`define ISCS_BLANK_TICKS    35
`define ISCS_RESET_TICKS    4
`define ISCS_STOP_TICKS     2
`define ISCS_PIX_DELAY      5

`endif

// >>> verilog/iscs_pkg.sv
// Types shared by the sequencer modules.
// Assumes nothing beyond a SystemVerilog compiler.
package iscs_pkg;

    typedef struct packed {
        logic [3:0]  addr;
        logic [11:0] data;
    } iscs_upload_t;

    typedef enum logic [2:0] {
        SH_IDLE,
        SH_RESET,
        SH_INTEG,
        SH_STOPPING,
        SH_READABLE
    } iscs_shut_state_t;

endpackage

// >>> verilog/iscs_upload.sv
// Register upload ports: parallel word port and 3-wire serial port.
// Assumes all pins are asynchronous to ref_clk_in and held stable around strobes.
`timescale 1ns/1ps
`default_nettype none
`include "iscs_map.svh"

module iscs_upload
    import iscs_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        ce_in,
    input  wire logic        if_mode_in,
    input  wire logic        serial_port_select_in,
    input  wire logic [15:0] p_data_in,
    input  wire logic        p_write_in,
    input  wire logic        s_clk_in,
    input  wire logic        s_data_in,
    input  wire logic        s_en_in,
    output logic             wr_out,
    output iscs_upload_t     word_out
);

    localparam int SW = `ISCS_WORD_BITS + 6;

    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    logic [2:0]    edge_r;
    logic [15:0]   shift_r;

    // Two-stage synchronisers on every pin except ce_in and arst_n_in
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else if (ce_in) begin
            sync1_r <= {if_mode_in, serial_port_select_in, p_write_in,
                        s_clk_in, s_data_in, s_en_in, p_data_in};
            sync2_r <= sync1_r;
        end
    end

    wire        if_s   = sync2_r[SW-1];
    wire        ser_s  = sync2_r[SW-2];
    wire        pw_s   = sync2_r[SW-3];
    wire        sck_s  = sync2_r[SW-4];
    wire        sd_s   = sync2_r[SW-5];
    wire        sen_s  = sync2_r[SW-6];
    wire [15:0] pdat_s = sync2_r[15:0];

    wire pw_rise  = pw_s & ~edge_r[2];
    wire sck_rise = sck_s & ~edge_r[1];
    wire sen_rise = sen_s & ~edge_r[0];
    wire sel_par  = if_s;
    wire sel_ser  = ~if_s & ser_s;
    wire load_par = sel_par & pw_rise;
    wire load_ser = sel_ser & sen_rise;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            edge_r   <= '0;
            shift_r  <= '0;
            wr_out   <= 1'b0;
            word_out <= '0;
        end else if (ce_in) begin
            edge_r <= {pw_s, sck_s, sen_s};
            if (sel_ser && sck_rise) begin
                shift_r <= {shift_r[14:0], sd_s};
            end
            wr_out <= load_par | load_ser;
            if (load_par) begin
                word_out <= pdat_s;
            end else if (load_ser) begin
                word_out <= shift_r;
            end
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in || !ce_in);

    property p_par_priority;
        (if_s && !pw_rise) |=> !wr_out;
    endproperty
    a_par_priority: assert property (p_par_priority) else $error("serial load taken in parallel mode");

    property p_par_word;
        load_par |=> (wr_out && word_out == $past(pdat_s));
    endproperty
    a_par_word: assert property (p_par_word) else $error("parallel word not latched");

endmodule // iscs_upload

`default_nettype wire

// >>> verilog/iscs_top.sv
// Control sequencer of the image sensor: uploads, shutter, row and pixel timing.
// Assumes control pulses are synchronous to ref_clk_in, upload pins are not.
`timescale 1ns/1ps
`default_nettype none
`include "iscs_map.svh"

module iscs_top
    import iscs_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        ce_in,
    input  wire logic        if_mode_in,
    input  wire logic        serial_port_select_in,
    input  wire logic [15:0] p_data_in,
    input  wire logic        p_write_in,
    input  wire logic        s_clk_in,
    input  wire logic        s_data_in,
    input  wire logic        s_en_in,
    input  wire logic        ss_start_in,
    input  wire logic        ss_stop_in,
    input  wire logic        row_clk_in,
    input  wire logic        row_start_in,
    input  wire logic        col_load_in,
    input  wire logic [9:0]  adc_code_in,
    output logic [6:0]       coarse_offset_out,
    output logic [6:0]       fine_offset_out,
    output logic [9:0]       adc_data_out,
    output logic             adc_data_oe_out,
    output logic             timeout_out,
    output logic             pixel_array_reset_out,
    output logic             array_readable_out,
    output logic             pixel_valid_out,
    output logic             last_line_out,
    output logic [10:0]      row_pointer_out,
    output logic             analog_pixel_valid_out
);

    // Register upload
    logic         upl_wr;
    iscs_upload_t upl_word;
    logic [11:0]  regs_r [16];

    iscs_upload u_upload (
        .ref_clk_in            (ref_clk_in),
        .arst_n_in             (arst_n_in),
        .ce_in                 (ce_in),
        .if_mode_in            (if_mode_in),
        .serial_port_select_in (serial_port_select_in),
        .p_data_in             (p_data_in),
        .p_write_in            (p_write_in),
        .s_clk_in              (s_clk_in),
        .s_data_in             (s_data_in),
        .s_en_in               (s_en_in),
        .wr_out                (upl_wr),
        .word_out              (upl_word)
    );

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < 16; i++) begin
                regs_r[i] <= `ISCS_REG_RST;
            end
        end else if (ce_in && upl_wr) begin
            regs_r[upl_word.addr] <= upl_word.data;
        end
    end

    wire [6:0]  coarse_w   = regs_r[`ISCS_A_COARSE][6:0];
    wire [6:0]  fine_w     = regs_r[`ISCS_A_FINE][6:0];
    wire [2:0]  adc_cfg    = regs_r[`ISCS_A_ADC][2:0];
    wire [1:0]  col_gran   = regs_r[`ISCS_A_GRAN][`ISCS_COL_GRAN_LSB +: 2];
    wire [1:0]  ss_gran    = regs_r[`ISCS_A_GRAN][`ISCS_SS_GRAN_LSB +: 2];
    wire [11:0] int_time_w = regs_r[`ISCS_A_INT_TIME];
    wire [11:0] ppr_w      = regs_r[`ISCS_A_PIX_ROW];
    wire [11:0] rows_w     = regs_r[`ISCS_A_ROWS];
    wire [10:0] row_pos_w  = regs_r[`ISCS_A_ROW_POS][10:0];

    // Converter output path
    function automatic logic [9:0] iscs_compress(input logic [9:0] x);
        if (x < 10'h100) begin
            iscs_compress = {x[8:0], 1'b0};
        end else if (x < 10'h300) begin
            iscs_compress = 10'h200 + {1'b0, x[9:1]} - 10'h080;
        end else begin
            iscs_compress = x;
        end
    endfunction

    wire [9:0] adc_curve = adc_cfg[`ISCS_ADC_LIN_BIT] ? adc_code_in
                                                      : iscs_compress(adc_code_in);
    wire [9:0] adc_pol   = adc_cfg[`ISCS_ADC_POL_BIT] ? adc_curve : ~adc_curve;

    // Shutter sequencer
    iscs_shut_state_t sh_state_r;
    iscs_shut_state_t sh_state_nxt;
    logic [8:0]       ss_presc_r;
    logic [1:0]       phase_r;
    logic [11:0]      int_cnt_r;
    logic             timeout_r;

    wire [8:0] ss_div  = `ISCS_SS_DIV_BASE << ss_gran;
    wire       ss_hold = ss_start_in | ss_stop_in;
    wire       ss_tick = ~ss_hold & (ss_presc_r == ss_div - 9'h001);
    wire       int_run = (sh_state_r == SH_RESET) || (sh_state_r == SH_INTEG);
    wire       int_hit = int_run && (int_cnt_r != int_time_w)
                         && (int_cnt_r + 12'h001 == int_time_w);

    always_comb begin
        sh_state_nxt = sh_state_r;
        case (sh_state_r)
            SH_RESET: begin
                if (phase_r == 2'(`ISCS_RESET_TICKS - 1)) begin
                    sh_state_nxt = SH_INTEG;
                end
            end
            SH_STOPPING: begin
                if (phase_r == 2'(`ISCS_STOP_TICKS - 1)) begin
                    sh_state_nxt = SH_READABLE;
                end
            end
            default: sh_state_nxt = sh_state_r;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ss_presc_r <= '0;
        end else if (ce_in) begin
            ss_presc_r <= (ss_hold || ss_tick) ? 9'h000 : ss_presc_r + 9'h001;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sh_state_r <= SH_IDLE;
            phase_r    <= '0;
            int_cnt_r  <= '0;
            timeout_r  <= 1'b0;
        end else if (ce_in) begin
            if (ss_start_in) begin
                sh_state_r <= SH_RESET;
                phase_r    <= '0;
                int_cnt_r  <= '0;
                timeout_r  <= 1'b0;
            end else if (ss_stop_in) begin
                sh_state_r <= SH_STOPPING;
                phase_r    <= '0;
            end else if (ss_tick) begin
                sh_state_r <= sh_state_nxt;
                phase_r    <= (sh_state_nxt != sh_state_r) ? 2'h0 : phase_r + 2'h1;
                if (int_run && int_cnt_r != int_time_w) begin
                    int_cnt_r <= int_cnt_r + 12'h001;
                end
                timeout_r <= int_hit;
            end
        end
    end

    // Row and column sequencer
    logic        row_clk_q_r;
    logic        row_start_q_r;
    logic        col_load_q_r;
    logic        blank_r;
    logic [5:0]  col_presc_r;
    logic [5:0]  blank_cnt_r;
    logic        col_sync_r;
    logic [11:0] pix_cnt_r;
    logic [11:0] line_cnt_r;
    logic [`ISCS_PIX_DELAY-2:0] pix_dly_r;

    wire       row_fall   = row_clk_q_r & ~row_clk_in;
    wire       start_rise = row_start_in & ~row_start_q_r;
    wire       load_rise  = col_load_in & ~col_load_q_r;
    wire       row_begin  = row_fall | start_rise;
    wire [5:0] col_div    = `ISCS_COL_DIV_BASE << col_gran;
    wire       col_tick   = blank_r & ~row_clk_in & (col_presc_r == col_div - 6'h01);
    wire       blank_last = col_tick && (blank_cnt_r == 6'(`ISCS_BLANK_TICKS - 1));
    wire       x_start    = col_sync_r | load_rise;
    wire [11:0] line_nxt  = line_cnt_r + 12'h001;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            row_clk_q_r   <= 1'b0;
            row_start_q_r <= 1'b0;
            col_load_q_r  <= 1'b0;
            pix_dly_r     <= '0;
        end else if (ce_in) begin
            row_clk_q_r   <= row_clk_in;
            row_start_q_r <= row_start_in;
            col_load_q_r  <= col_load_in;
            pix_dly_r     <= {pix_dly_r[`ISCS_PIX_DELAY-3:0], x_start};
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            blank_r     <= 1'b0;
            col_presc_r <= '0;
            blank_cnt_r <= '0;
            col_sync_r  <= 1'b0;
        end else if (ce_in) begin
            col_sync_r <= blank_last;
            if (row_begin) begin
                blank_r     <= 1'b1;
                col_presc_r <= '0;
                blank_cnt_r <= '0;
            end else if (blank_r && !row_clk_in) begin
                col_presc_r <= col_tick ? 6'h00 : col_presc_r + 6'h01;
                if (col_tick) begin
                    blank_cnt_r <= blank_cnt_r + 6'h01;
                end
                if (blank_last) begin
                    blank_r <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pix_cnt_r       <= '0;
            pixel_valid_out <= 1'b0;
        end else if (ce_in) begin
            if (x_start) begin
                pix_cnt_r       <= '0;
                pixel_valid_out <= 1'b1;
            end else if (pixel_valid_out && !row_clk_in) begin
                if (pix_cnt_r == ppr_w) begin
                    pixel_valid_out <= 1'b0;
                end else begin
                    pix_cnt_r <= pix_cnt_r + 12'h001;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            line_cnt_r      <= '0;
            last_line_out   <= 1'b0;
            row_pointer_out <= '0;
        end else if (ce_in) begin
            if (start_rise) begin
                line_cnt_r      <= '0;
                last_line_out   <= (rows_w == 12'h000);
                row_pointer_out <= row_pos_w;
            end else if (row_fall) begin
                line_cnt_r      <= line_nxt;
                last_line_out   <= (line_nxt == rows_w);
                row_pointer_out <= row_pointer_out + 11'h001;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            coarse_offset_out      <= '0;
            fine_offset_out        <= '0;
            adc_data_out           <= '0;
            adc_data_oe_out        <= 1'b0;
            timeout_out            <= 1'b0;
            pixel_array_reset_out  <= 1'b0;
            array_readable_out     <= 1'b0;
            analog_pixel_valid_out <= 1'b0;
        end else if (ce_in) begin
            coarse_offset_out      <= coarse_w;
            fine_offset_out        <= fine_w;
            adc_data_out           <= adc_pol;
            adc_data_oe_out        <= adc_cfg[`ISCS_ADC_DRIVE_BIT];
            timeout_out            <= timeout_r;
            pixel_array_reset_out  <= (sh_state_r == SH_RESET);
            array_readable_out     <= (sh_state_r == SH_READABLE);
            analog_pixel_valid_out <= pix_dly_r[`ISCS_PIX_DELAY-2];
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in || !ce_in);

    sequence s_out_valid5;
        ##5 analog_pixel_valid_out;
    endsequence

    sequence s_tmo_hold;
        (timeout_out || ss_start_in) [*8];
    endsequence

    property p_coarse_top;
        (coarse_w == 7'h7f) |=> (coarse_offset_out == 7'h7f);
    endproperty
    a_coarse_top: assert property (p_coarse_top) else $error("coarse offset not applied");

    property p_adc_float;
        !adc_cfg[0] |=> !adc_data_oe_out;
    endproperty
    a_adc_float: assert property (p_adc_float) else $error("pixel outputs driven while off");

    property p_adc_linear;
        (adc_cfg == 3'h7) |=> (adc_data_out == $past(adc_code_in));
    endproperty
    a_adc_linear: assert property (p_adc_linear) else $error("linear conversion wrong");

    property p_adc_invert;
        (adc_cfg == 3'h3) |=> (adc_data_out == ~$past(adc_code_in));
    endproperty
    a_adc_invert: assert property (p_adc_invert) else $error("inverted output wrong");

    property p_upload_only;
        (upl_wr && upl_word.addr != `ISCS_A_INT_TIME) |=> $stable(int_time_w);
    endproperty
    a_upload_only: assert property (p_upload_only) else $error("unaddressed register changed");

    property p_ss_suspend;
        ss_hold |=> (ss_presc_r == 9'h000) && ($past(ss_start_in) || $stable(int_cnt_r));
    endproperty
    a_ss_suspend: assert property (p_ss_suspend) else $error("shutter ran while suspended");

    property p_timeout_width;
        $rose(timeout_out) |-> s_tmo_hold;
    endproperty
    a_timeout_width: assert property (p_timeout_width) else $error("timeout pulse too short");

    property p_reset_phase;
        $fell(ss_start_in) |=> pixel_array_reset_out [*8];
    endproperty
    a_reset_phase: assert property (p_reset_phase) else $error("pixel reset phase missing");

    property p_stop_phase;
        $fell(ss_stop_in) |-> !array_readable_out [*8];
    endproperty
    a_stop_phase: assert property (p_stop_phase) else $error("array readable too early");

    property p_blank_140;
        (row_fall && col_gran == 2'h0) |-> ##141 col_sync_r;
    endproperty
    a_blank_140: assert property (p_blank_140) else $error("blanking length wrong");

    property p_pv_rise;
        x_start |=> pixel_valid_out;
    endproperty
    a_pv_rise: assert property (p_pv_rise) else $error("pixel valid not raised");

    property p_last_hold;
        (last_line_out && !row_fall && !start_rise) |=> last_line_out;
    endproperty
    a_last_hold: assert property (p_last_hold) else $error("last line dropped early");

    property p_row_load;
        start_rise |=> (row_pointer_out == $past(row_pos_w));
    endproperty
    a_row_load: assert property (p_row_load) else $error("row pointer not loaded");

    property p_pix_out;
        x_start |-> s_out_valid5;
    endproperty
    a_pix_out: assert property (p_pix_out) else $error("pixel output valid late");

endmodule // iscs_top

`default_nettype wire

// >>> verification/iscs_ctrl_model.sv
// Controller model: presents one upload word on the parallel port per go request.
// Assumes go_in is driven just after a rising edge and held one cycle.
`timescale 1ns/1ps
`default_nettype none

module iscs_ctrl_model (
    input  wire logic        ref_clk_in,
    input  wire logic        go_in,
    input  wire logic [15:0] word_in,
    output logic [15:0]      p_data_out,
    output logic             p_write_out,
    output logic             busy_out
);
    initial begin
        p_data_out = 16'h0000;
        p_write_out = 1'b0;
        busy_out = 1'b0;
    end

    // Parallel port only, changes just after the active edge
    always begin
        @(posedge ref_clk_in);
        if (go_in) begin
            #1 p_data_out = word_in;
            busy_out = 1'b1;
            repeat (2) @(posedge ref_clk_in);
            #1 p_write_out = 1'b1;
            repeat (3) @(posedge ref_clk_in);
            #1 p_write_out = 1'b0;
            repeat (3) @(posedge ref_clk_in);
            busy_out = 1'b0;
            #1 p_data_out = ~p_data_out;
        end
    end
endmodule // iscs_ctrl_model

`default_nettype wire

// >>> verification/tb_top.sv
// Testbench of the sequencer: uploads, converter path, rows and shutter.
// Assumes the design files and iscs_ctrl_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import iscs_pkg::*;
    logic ref_clk_in = 0, arst_n_in = 0, ce_in = 1, if_mode_in = 1;
    logic serial_port_select_in = 1, s_clk_in = 0, s_data_in = 0, s_en_in = 0;
    logic ss_start_in = 0, ss_stop_in = 0, row_clk_in = 0, row_start_in = 0;
    logic col_load_in = 0, go = 0, busy, p_write_in;
    logic [15:0] p_data_in, word = 0;
    logic [9:0] adc_code_in = 0, adc_data_out, x;
    logic [6:0] coarse_offset_out, fine_offset_out;
    logic [10:0] row_pointer_out;
    logic adc_data_oe_out, timeout_out, pixel_array_reset_out, array_readable_out;
    logic pixel_valid_out, last_line_out, analog_pixel_valid_out;
    int n_mismatch = 0, n_tests = 0, seed = 32'h9952, k, j, ph, at;

    always #10 ref_clk_in = ~ref_clk_in;

    iscs_top DUT (.*);
    iscs_ctrl_model PM (.ref_clk_in, .go_in(go), .word_in(word),
        .p_data_out(p_data_in), .p_write_out(p_write_in), .busy_out(busy));

    task automatic tick(input int n = 1);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic lim(input int n, input int b);
        if (n >= b) begin
            chk("wait", 16'h0000, 16'hffff);
            print_verdict;
        end
    endtask

    task automatic pwr(input logic [15:0] w);
        word = w;
        go = 1;
        tick();
        go = 0;
        tick(2);
        for (k = 0; busy && k < 20; k++) tick();
        lim(k, 20);
    endtask

    task automatic swr(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            s_data_in = w[i];
            tick(3);
            s_clk_in = 1;
            tick(3);
            s_clk_in = 0;
        end
        tick(3);
        s_en_in = 1;
        tick(3);
        s_en_in = 0;
        tick(6);
    endtask

    function automatic logic [9:0] conv(input logic [9:0] v, input logic [2:0] c);
        int y;
        y = c[1] ? v : (v < 256 ? 2 * v : (v < 768 ? v / 2 + 384 : v));
        return c[2] ? 10'(y) : ~10'(y);
    endfunction

    initial begin
        tick(12);
        arst_n_in = 1;
        tick();
        chk("coarse", 0, coarse_offset_out);
        chk("rowptr", 0, row_pointer_out);
        pwr(16'h007f);
        chk("coarse", 16'h7f, coarse_offset_out);
        pwr(16'h1040);
        chk("fine", 16'h40, fine_offset_out);
        pwr(16'hffff);
        chk("coarse", 16'h7f, coarse_offset_out);
        swr(16'h0012);
        chk("coarse", 16'h7f, coarse_offset_out);
        if_mode_in = 0;
        swr(16'h0005);
        chk("coarse", 16'h05, coarse_offset_out);
        pwr(16'h0011);
        chk("coarse", 16'h05, coarse_offset_out);
        serial_port_select_in = 0;
        swr(16'h0033);
        chk("coarse", 16'h05, coarse_offset_out);
        if_mode_in = 1;
        for (int c = 0; c < 8; c++) begin
            pwr(16'h2000 | 16'(c));
            for (int r = 0; r < 6; r++) begin
                x = 10'($random(seed));
                adc_code_in = x;
                tick();
                chk("oe", 16'(c & 1), adc_data_oe_out);
                if (c & 1) chk("adc", conv(x, 3'(c)), adc_data_out);
            end
        end
        pwr(16'h5003);
        pwr(16'h6001);
        pwr(16'h702a);
        row_start_in = 1;
        tick(3);
        row_start_in = 0;
        tick();
        chk("rowptr", 16'h2a, row_pointer_out);
        row_clk_in = 1;
        tick();
        row_clk_in = 0;
        for (k = 0; !pixel_valid_out && k < 400; k++) tick();
        lim(k, 400);
        chk("blank", 1, k >= 142 && k <= 143);
        chk("last", 1, last_line_out);
        ph = 0;
        at = 0;
        for (j = 0; j < 10; j++) begin
            ph += pixel_valid_out;
            if (analog_pixel_valid_out) at = j;
            tick();
        end
        chk("pvlen", 4, ph);
        chk("apv", 4, at);
        row_clk_in = 1;
        tick();
        row_clk_in = 0;
        tick(2);
        chk("last", 0, last_line_out);
        pwr(16'h400a);
        ss_start_in = 1;
        tick();
        ss_start_in = 0;
        tick();
        chk("pxrst", 1, pixel_array_reset_out);
        for (k = 0; pixel_array_reset_out && k < 300; k++) tick();
        chk("rstlen", 1, k >= 127 && k <= 129);
        for (k = 0; !timeout_out && k < 1000; k++) tick();
        lim(k, 1000);
        for (j = 0; timeout_out && j < 40; j++) tick();
        chk("tmolen", 32, j);
        ss_stop_in = 1;
        tick();
        ss_stop_in = 0;
        for (k = 0; !array_readable_out && k < 200; k++) tick();
        chk("ready", 1, k >= 63 && k <= 66);
        col_load_in = 1;
        tick();
        col_load_in = 0;
        chk("pvload", 1, pixel_valid_out);
        for (k = 0; !analog_pixel_valid_out && k < 20; k++) tick();
        chk("apvload", 4, k);
        ce_in = 0;
        pwr(16'h0066);
        ce_in = 1;
        tick(4);
        chk("cefreeze", 16'h05, coarse_offset_out);
        arst_n_in = 0;
        tick(6);
        arst_n_in = 1;
        tick();
        chk("coarse", 0, coarse_offset_out);
        chk("ready", 0, array_readable_out);
        print_verdict;
    end
endmodule // tb_top

`default_nettype wire
